// file: bench/icr_ata_dev.sv
// ATA device stand-in for the register bank bench.
// Assumes command and status-read strobes come from icr_regs.
`timescale 1ns/10ps
module icr_ata_dev #(parameter int BUSY_CYC = 6) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       cmd_i,
    input  wire logic       stat_rd_i,
    output logic [7:0]      status_o,
    output logic [1:0]      intrq_o,
    output logic            cable80_o
);
    int   cnt;
    logic irq;
    // Busy after a command, then interrupt until status is read
    always @(posedge clk_sys_i) begin
        if (!rstn_i || stat_rd_i) irq <= 1'b0;
        if (!rstn_i) cnt <= 0;
        else if (cmd_i) cnt <= BUSY_CYC;
        else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) irq <= 1'b1;
        end
    end
    assign status_o  = (cnt > 0) ? 8'h80 : 8'h50;
    assign intrq_o   = {irq, irq};
    assign cable80_o = 1'b1;
endmodule

// file: bench/ide_channel_config_regs_tb_top.sv
// Self-checking bench for the channel register bank.
// Assumes icr_regs and the icr_ata_dev device stand-in.
`timescale 1ns/10ps
module ide_channel_config_regs_tb_top;
    localparam logic [31:0] B = 32'h00001000;
    logic                clk_sys_i = 1'b0;
    logic                rstn_i = 1'b0;
    icr_pkg::icr_req_s   req_i = '0;
    logic [7:0]          ata_status_i;
    logic [1:0]          ata_intrq_i, clk_sel_o, pio_iordy_o;
    logic                cable80_i, ack_o, hit_o, ata_cmd_o, ata_stat_rd_o;
    logic                pci_int_o, io_en_o, mem_en_o, master_en_o, tf_iordy_o;
    logic [31:0]         rdata_o, pio_tim_o, mdma_tim_o, udma_tim_o, rd;
    logic [5:0]          rd_thr_o, wr_thr_o;
    logic [15:0]         tf_timing_o;
    icr_pkg::icr_ata_s   ata_o, tf;
    icr_pkg::icr_xmode_e dev0_mode_o, dev1_mode_o;
    logic                ht, cm;
    int                  n_errors = 0, total_checks = 0, cyc = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    icr_regs DUT (.clk_sys_i, .rstn_i, .req_i, .ata_status_i, .ata_intrq_i,
        .cable80_i, .ack_o, .hit_o, .rdata_o, .ata_o, .ata_cmd_o,
        .ata_stat_rd_o, .pci_int_o, .io_en_o, .mem_en_o, .master_en_o,
        .clk_sel_o, .rd_thr_o, .wr_thr_o, .tf_timing_o, .tf_iordy_o,
        .pio_tim_o, .mdma_tim_o, .udma_tim_o, .dev0_mode_o, .dev1_mode_o,
        .pio_iordy_o);
    icr_ata_dev dev (.clk_sys_i, .rstn_i, .cmd_i(ata_cmd_o),
        .stat_rd_i(ata_stat_rd_o), .status_o(ata_status_i),
        .intrq_o(ata_intrq_i), .cable80_o(cable80_i));

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Called at a falling edge; taken at the next rising edge, and the
    // one-cycle answer is captured at the falling edge right after it
    task automatic acc(input icr_pkg::icr_space_e sp, input logic w,
                       input logic [31:0] a, input logic [3:0] be,
                       input logic [31:0] d);
        req_i = '{1'b1, sp, w, a, be, d};
        @(negedge clk_sys_i);
        chk({31'h0, ack_o}, 32'h1);
        rd = rdata_o;
        ht = hit_o;
        tf = ata_o;
        cm = ata_cmd_o;
        req_i = '0;
        @(negedge clk_sys_i);
    endtask

    task automatic mw(input logic [31:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        acc(icr_pkg::ICR_SP_MEM, 1'b1, B + a, b, d);
    endtask

    task automatic mr(input logic [31:0] a, input logic [3:0] b);
        acc(icr_pkg::ICR_SP_MEM, 1'b0, B + a, b, 32'h0);
    endtask

    task automatic cw(input logic [31:0] a, input logic [31:0] d);
        acc(icr_pkg::ICR_SP_CFG, 1'b1, a, 4'hF, d);
    endtask

    // Write a command byte, then poll status until busy clears
    task automatic cmd(input logic [7:0] c);
        int n;
        n = 0;
        mw(32'h84, 4'h8, {c, 24'h0});
        chk({25'h0, cm, tf.lanes, tf.word}, {25'h0, 1'b1, 4'h8, 2'h1});
        chk(tf.data, {c, 24'h0});
        mr(32'h84, 4'h8);
        chk({24'h0, rd[31:24]}, 32'h00000080);
        while (rd[31] && n < 20) begin
            mr(32'h84, 4'h8);
            n++;
        end
        chk({24'h0, rd[31:24]}, 32'h00000050);
    endtask

    task automatic t_enable();
        acc(icr_pkg::ICR_SP_CFG, 1'b0, 32'h88, 4'hF, 32'h0);
        chk(rd, 32'h00000000);
        chk(pio_tim_o, 32'hFFFFFFFF);
        chk({16'h0, tf_timing_o}, 32'h0000FFFF);
        acc(icr_pkg::ICR_SP_MEM, 1'b0, 32'h48, 4'hF, 32'h0);
        chk({31'h0, ht}, 32'h0);
        acc(icr_pkg::ICR_SP_IO, 1'b0, 32'h0, 4'hF, 32'h0);
        chk({31'h0, ht}, 32'h0);
        cw(32'h24, B);
        cw(32'h04, 32'h00000007);
        chk({29'h0, master_en_o, mem_en_o, io_en_o}, 32'h7);
        mr(32'hFC, 4'hF);
        chk({31'h0, ht}, 32'h1);
        mr(32'h100, 4'hF);
        chk({31'h0, ht}, 32'h0);
        cw(32'h30, 32'h00080001);
        acc(icr_pkg::ICR_SP_MEM, 1'b0, 32'h000FFFFC, 4'hF, 32'h0);
        chk({31'h0, ht}, 32'h1);
    endtask

    task automatic t_regs();
        cw(32'h88, 32'h00300000);
        chk({30'h0, clk_sel_o}, 32'h3);
        mr(32'h48, 4'hF);
        chk(rd, 32'h00300000);
        mw(32'hB0, 4'hF, 32'hFFFF2A15);
        chk({20'h0, wr_thr_o, rd_thr_o}, 32'h00000A95);
        mw(32'hA0, 4'hF, 32'hFFFFFFFF);
        chk(rd, 32'h0);
        chk({15'h0, tf_iordy_o, tf_timing_o}, 32'h0001FFFF);
        mr(32'hA0, 4'hF);
        chk(rd, 32'hFFFF0201);
        mw(32'hA0, 4'hF, 32'h12340000);
        chk({15'h0, tf_iordy_o, tf_timing_o}, 32'h00001234);
        mw(32'hA4, 4'hF, 32'h1111AAAA);
        chk(pio_tim_o, 32'h1111AAAA);
        mw(32'hA8, 4'hF, 32'h2222BBBB);
        chk(mdma_tim_o, 32'h2222BBBB);
        mw(32'hAC, 4'hF, 32'h3333CCCC);
        chk(udma_tim_o, 32'h3333CCCC);
        for (int m = 0; m < 4; m++) begin
            mw(32'hB4, 4'h1, {26'h0, 2'(m), 2'h0, 2'(3 - m)});
            chk({28'h0, dev1_mode_o, dev0_mode_o}, {28'h0, 2'(m), 2'(3 - m)});
            chk({30'h0, pio_iordy_o}, {30'h0, m != 0, m != 3});
        end
    endtask

    task automatic t_irq();
        mw(32'h80, 4'h4, 32'h00110000);
        mw(32'h84, 4'h4, 32'h000F0000);
        mw(32'h84, 4'h8, 32'h91000000);
        repeat (10) @(negedge clk_sys_i);
        chk({31'h0, pci_int_o}, 32'h1);
        cw(32'h88, 32'h00C00000);
        repeat (2) @(negedge clk_sys_i);
        chk({31'h0, pci_int_o}, 32'h0);
        cw(32'h88, 32'h00400000);
        repeat (2) @(negedge clk_sys_i);
        chk({31'h0, pci_int_o}, 32'h1);
        mr(32'h84, 4'h8);
        repeat (2) @(negedge clk_sys_i);
        chk({31'h0, pci_int_o}, 32'h0);
    endtask

    task automatic t_taskfile();
        mw(32'h88, 4'h4, 32'h0);
        chk({26'h0, tf.lanes, tf.word}, {26'h0, 4'h4, 2'h2});
        mw(32'h84, 4'h7, 32'h00A01234);
        chk({25'h0, cm, tf.lanes, tf.word}, {25'h0, 1'b0, 4'h7, 2'h1});
        chk(tf.data & 32'h00FFFFFF, 32'h00A01234);
        mw(32'h80, 4'h4, 32'h00100000);
        cmd(8'hC6);
        mw(32'h80, 4'hE, 32'h01450300);
        chk({26'h0, tf.lanes, tf.word}, {26'h0, 4'hE, 2'h0});
        chk(tf.data & 32'hFFFFFF00, 32'h01450300);
        cmd(8'hEF);
    endtask

    task automatic t_rerun();
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_sys_i);
        chk(udma_tim_o, 32'hFFFFFFFF);
        chk({14'h0, clk_sel_o, wr_thr_o, rd_thr_o, 4'h0}, 32'h0);
        chk({28'h0, dev1_mode_o, dev0_mode_o}, 32'h0);
        chk({16'h0, tf_timing_o}, 32'h0000FFFF);
        rstn_i = 1'b1;
        @(negedge clk_sys_i);
    endtask

    initial begin
        repeat (2) @(negedge clk_sys_i);
        rstn_i = 1'b1;
        @(negedge clk_sys_i);
        t_enable();
        t_regs();
        t_irq();
        t_taskfile();
        t_rerun();
        conclude();
    end
endmodule

// file: verilog/icr_pkg.sv
// Constants, types and layouts for the channel configuration register bank.
// Assumes a decoded host access port and a task-file side that accepts
// per-lane byte writes; all logic runs on the host bus clock.
//
// Contract
// - Decode windows of 8, 4, 8, 4, 16 bytes in I/O and 256 bytes in memory.
// - Decode a 512 KB expansion ROM window once based and enabled.
// - Command bits 2..0 enable I/O response, memory response, bus mastering.
// - Clock select at bits 21..20 of system config, at 0x88 and window 0x48.
// - FIFO read threshold bits 5..0, write threshold bits 13..8.
// - Bits 23..22 of system config block channel interrupts from host.
// - Write to word 1 top byte issues a command; read returns status.
// - Word 1 lanes carry device/head, cylinder high, cylinder low.
// - Word 0 lanes carry start sector, sector count, features.
// - Word 2 bits 23..16 go to the device control register.
// - Channel timing bit 0 reports the cable detect indication.
// - Channel timing bits 31..16 time non-data task-file accesses, shared.
// - Channel timing bit 9 enables IORDY monitoring on task-file accesses.
// - Pio_data_timing low half for device 0, high half device 1; slow reset.
// - Multiword DMA timing low half device 0, high half device 1.
// - Ultra DMA timing low half device 0, high half device 1.
// - Transfer mode fields at bits 1..0 and 5..4, four encodings.
// - Nonzero transfer mode enables IORDY monitoring on PIO data accesses.
package icr_pkg;

    typedef enum logic [1:0] {ICR_SP_IDLE, ICR_SP_CFG, ICR_SP_IO,
                              ICR_SP_MEM} icr_space_e;

    // Order gives codes 00, 01, 10, 11
    typedef enum logic [1:0] {ICR_PIO_PLAIN, ICR_PIO_IORDY, ICR_MDMA,
                              ICR_UDMA} icr_xmode_e;

    typedef struct packed {
        logic        valid;
        icr_space_e  space;
        logic        write;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } icr_req_s;

    typedef struct packed {
        logic [3:0]  lanes;
        logic [1:0]  word;
        logic [31:0] data;
    } icr_ata_s;

    // Configuration space offsets
    localparam logic [7:0] ICR_CFG_CMD  = 8'h04;
    localparam logic [7:0] ICR_CFG_BAR0 = 8'h10;
    localparam logic [7:0] ICR_CFG_ROM  = 8'h30;
    localparam logic [7:0] ICR_CFG_SYS  = 8'h88;

    // Memory window offsets
    localparam logic [7:0] ICR_MEM_SYS   = 8'h48;
    localparam logic [7:0] ICR_MEM_TF0   = 8'h80;
    localparam logic [7:0] ICR_MEM_TF1   = 8'h84;
    localparam logic [7:0] ICR_MEM_TF2   = 8'h88;
    localparam logic [7:0] ICR_MEM_TIM   = 8'hA0;
    localparam logic [7:0] ICR_MEM_PIO   = 8'hA4;
    localparam logic [7:0] ICR_MEM_MDMA  = 8'hA8;
    localparam logic [7:0] ICR_MEM_UDMA  = 8'hAC;
    localparam logic [7:0] ICR_MEM_FIFO  = 8'hB0;
    localparam logic [7:0] ICR_MEM_XMODE = 8'hB4;

    // Window sizes as address masks
    localparam int         ICR_NBAR = 6;
    localparam logic [31:0] ICR_BAR_MASK [ICR_NBAR] = '{
        32'hFFFFFFF8, 32'hFFFFFFFC, 32'hFFFFFFF8,
        32'hFFFFFFFC, 32'hFFFFFFF0, 32'hFFFFFF00};
    localparam logic [ICR_NBAR-1:0] ICR_BAR_IO = 6'h1F;
    localparam logic [31:0] ICR_ROM_MASK = 32'hFFF80000;
    localparam int          ICR_ROM_EN   = 0;

    // Field positions
    localparam int ICR_CMD_IO   = 0;
    localparam int ICR_CMD_MEM  = 1;
    localparam int ICR_CMD_MST  = 2;
    localparam int ICR_SYS_CLK  = 20;
    localparam int ICR_SYS_BLK  = 22;
    localparam int ICR_TIM_IORDY = 9;
    localparam int ICR_STAT_LANE = 3;

    // Writable bits
    localparam logic [31:0] ICR_CMD_WMASK   = 32'h00000007;
    localparam logic [31:0] ICR_SYS_WMASK   = 32'h00F00000;
    localparam logic [31:0] ICR_FIFO_WMASK  = 32'h00003F3F;
    localparam logic [31:0] ICR_TIM_WMASK   = 32'hFFFF0200;
    localparam logic [31:0] ICR_XMODE_WMASK = 32'h00000033;
    localparam logic [31:0] ICR_ALL_WMASK   = 32'hFFFFFFFF;

    // Values after reset
    localparam logic [31:0] ICR_SYS_RST   = 32'h00000000;
    localparam logic [31:0] ICR_FIFO_RST  = 32'h00000000;
    localparam logic [31:0] ICR_TIM_RST   = 32'hFFFF0000;
    localparam logic [31:0] ICR_PIO_RST   = 32'hFFFFFFFF;
    localparam logic [31:0] ICR_MDMA_RST  = 32'hFFFFFFFF;
    localparam logic [31:0] ICR_UDMA_RST  = 32'hFFFFFFFF;
    localparam logic [31:0] ICR_XMODE_RST = 32'h00000000;

endpackage

// file: verilog/icr_regs.sv
// Channel configuration and task-file register bank.
// Assumes req_i is already decoded from the host bus and stable one cycle;
// the task-file side consumes byte-lane writes and supplies device status.
`timescale 1ns/10ps
module icr_regs (
    input  wire logic              clk_sys_i,
    input  wire logic              rstn_i,
    input  wire icr_pkg::icr_req_s req_i,
    input  wire logic [7:0]        ata_status_i,
    input  wire logic [1:0]        ata_intrq_i,
    input  wire logic              cable80_i,
    output logic                   ack_o,
    output logic                   hit_o,
    output logic [31:0]            rdata_o,
    output icr_pkg::icr_ata_s      ata_o,
    output logic                   ata_cmd_o,
    output logic                   ata_stat_rd_o,
    output logic                   pci_int_o,
    output logic                   io_en_o,
    output logic                   mem_en_o,
    output logic                   master_en_o,
    output logic [1:0]             clk_sel_o,
    output logic [5:0]             rd_thr_o,
    output logic [5:0]             wr_thr_o,
    output logic [15:0]            tf_timing_o,
    output logic                   tf_iordy_o,
    output logic [31:0]            pio_tim_o,
    output logic [31:0]            mdma_tim_o,
    output logic [31:0]            udma_tim_o,
    output icr_pkg::icr_xmode_e    dev0_mode_o,
    output icr_pkg::icr_xmode_e    dev1_mode_o,
    output logic [1:0]             pio_iordy_o
);

    //--------------------------------------------------------------
    // Storage
    //--------------------------------------------------------------
    logic [2:0]  cmd_r;
    logic [31:0] bar_r [icr_pkg::ICR_NBAR];
    logic [31:0] rom_r;
    logic [31:0] sys_r;
    logic [31:0] fifo_r;
    logic [31:0] tf0_r;
    logic [31:0] tf1_r;
    logic [31:0] tf2_r;
    logic [31:0] tim_r;
    logic [31:0] xmode_r;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] msk,
                                          input logic [3:0]  be);
        logic [31:0] bm;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
        return (old & ~bm) | (wd & bm);
    endfunction

    //--------------------------------------------------------------
    // Address decode
    //--------------------------------------------------------------
    wire [7:0]  off    = req_i.addr[7:0];
    wire        acc_cfg = req_i.valid && req_i.space == icr_pkg::ICR_SP_CFG;
    wire        acc_io  = req_i.valid && req_i.space == icr_pkg::ICR_SP_IO
                          && cmd_r[icr_pkg::ICR_CMD_IO];
    wire        acc_mem = req_i.valid && req_i.space == icr_pkg::ICR_SP_MEM
                          && cmd_r[icr_pkg::ICR_CMD_MEM];
    wire [icr_pkg::ICR_NBAR-1:0] bar_hit;
    wire [icr_pkg::ICR_NBAR-1:0] s_bar;

    genvar gi;
    generate
        for (gi = 0; gi < icr_pkg::ICR_NBAR; gi++) begin : g_bar
            localparam logic [31:0] MSK = icr_pkg::ICR_BAR_MASK[gi];
            localparam logic [7:0]  OFS =
                8'(icr_pkg::ICR_CFG_BAR0 + 4 * gi);
            wire sp_ok = icr_pkg::ICR_BAR_IO[gi] ? acc_io : acc_mem;
            // Window size set by the low bits kept at zero
            assign bar_hit[gi] = sp_ok
                && (req_i.addr & MSK) == bar_r[gi];
            assign s_bar[gi] = acc_cfg && off == OFS;
            always_ff @(posedge clk_sys_i) begin
                if (!rstn_i) begin
                    bar_r[gi] <= 32'h00000000;
                end else if (s_bar[gi] && req_i.write) begin
                    bar_r[gi] <= merge(bar_r[gi], req_i.wdata, MSK,
                                       req_i.be);
                end
            end
        end
    endgenerate

    wire rom_hit = acc_mem && rom_r[icr_pkg::ICR_ROM_EN]
        && (req_i.addr & icr_pkg::ICR_ROM_MASK)
           == (rom_r & icr_pkg::ICR_ROM_MASK);
    wire mem5   = bar_hit[5];
    wire s_cmd  = acc_cfg && off == icr_pkg::ICR_CFG_CMD;
    wire s_rom  = acc_cfg && off == icr_pkg::ICR_CFG_ROM;
    wire s_sys  = (acc_cfg && off == icr_pkg::ICR_CFG_SYS)
               || (mem5 && off == icr_pkg::ICR_MEM_SYS);
    wire s_fifo = mem5 && off == icr_pkg::ICR_MEM_FIFO;
    wire s_tf0  = (bar_hit[0] && !req_i.addr[2])
               || (mem5 && off == icr_pkg::ICR_MEM_TF0);
    wire s_tf1  = (bar_hit[0] && req_i.addr[2])
               || (mem5 && off == icr_pkg::ICR_MEM_TF1);
    wire s_tf2  = bar_hit[1] || (mem5 && off == icr_pkg::ICR_MEM_TF2);
    wire s_tim  = mem5 && off == icr_pkg::ICR_MEM_TIM;
    wire s_pio  = mem5 && off == icr_pkg::ICR_MEM_PIO;
    wire s_mdma = mem5 && off == icr_pkg::ICR_MEM_MDMA;
    wire s_udma = mem5 && off == icr_pkg::ICR_MEM_UDMA;
    wire s_xm   = mem5 && off == icr_pkg::ICR_MEM_XMODE;
    wire any_hit = acc_cfg || (|bar_hit) || rom_hit;
    wire wr_go  = req_i.write;
    wire rd_go  = !req_i.write;
    wire tf_wr  = wr_go && (s_tf0 || s_tf1 || s_tf2);
    wire cmd_wr = wr_go && s_tf1 && req_i.be[icr_pkg::ICR_STAT_LANE];
    wire st_rd  = rd_go && s_tf1 && req_i.be[icr_pkg::ICR_STAT_LANE];
    wire [1:0] tf_word = s_tf1 ? 2'h1 : (s_tf2 ? 2'h2 : 2'h0);

    //--------------------------------------------------------------
    // Read selection
    //--------------------------------------------------------------
    wire [31:0] bar_rd = ({32{s_bar[0]}} & (bar_r[0] | 32'h1))
                       | ({32{s_bar[1]}} & (bar_r[1] | 32'h1))
                       | ({32{s_bar[2]}} & (bar_r[2] | 32'h1))
                       | ({32{s_bar[3]}} & (bar_r[3] | 32'h1))
                       | ({32{s_bar[4]}} & (bar_r[4] | 32'h1))
                       | ({32{s_bar[5]}} & bar_r[5]);
    // Status byte comes live from the device, busy flag included
    wire [31:0] tf1_rd = {ata_status_i, tf1_r[23:0]};
    wire [31:0] tim_rd = {tim_r[31:1], cable80_i};
    wire [31:0] rd_word = bar_rd
        | ({32{s_cmd}}  & {29'h0, cmd_r})
        | ({32{s_rom}}  & rom_r)
        | ({32{s_sys}}  & sys_r)
        | ({32{s_fifo}} & fifo_r)
        | ({32{s_tf0}}  & tf0_r)
        | ({32{s_tf1}}  & tf1_rd)
        | ({32{s_tf2}}  & tf2_r)
        | ({32{s_tim}}  & tim_rd)
        | ({32{s_pio}}  & pio_tim_o)
        | ({32{s_mdma}} & mdma_tim_o)
        | ({32{s_udma}} & udma_tim_o)
        | ({32{s_xm}}   & xmode_r);

    //--------------------------------------------------------------
    // Configuration registers
    //--------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            cmd_r <= 3'h0;
            rom_r <= 32'h00000000;
            sys_r <= icr_pkg::ICR_SYS_RST;
        end else begin
            if (s_cmd && wr_go)
                cmd_r <= req_i.be[0] ? req_i.wdata[2:0] : cmd_r;
            if (s_rom && wr_go)
                rom_r <= merge(rom_r, req_i.wdata,
                               icr_pkg::ICR_ROM_MASK | 32'h1,
                               req_i.be);
            if (s_sys && wr_go)
                sys_r <= merge(sys_r, req_i.wdata,
                               icr_pkg::ICR_SYS_WMASK, req_i.be);
        end
    end

    //--------------------------------------------------------------
    // Channel registers
    //--------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            fifo_r  <= icr_pkg::ICR_FIFO_RST;
            tim_r   <= icr_pkg::ICR_TIM_RST;
            xmode_r <= icr_pkg::ICR_XMODE_RST;
            pio_tim_o  <= icr_pkg::ICR_PIO_RST;
            mdma_tim_o <= icr_pkg::ICR_MDMA_RST;
            udma_tim_o <= icr_pkg::ICR_UDMA_RST;
        end else if (wr_go) begin
            if (s_fifo)
                fifo_r <= merge(fifo_r, req_i.wdata,
                                icr_pkg::ICR_FIFO_WMASK, req_i.be);
            if (s_tim)
                tim_r <= merge(tim_r, req_i.wdata,
                               icr_pkg::ICR_TIM_WMASK, req_i.be);
            if (s_xm)
                xmode_r <= merge(xmode_r, req_i.wdata,
                                 icr_pkg::ICR_XMODE_WMASK,
                                 req_i.be);
            if (s_pio)
                pio_tim_o <= merge(pio_tim_o, req_i.wdata,
                                   icr_pkg::ICR_ALL_WMASK,
                                   req_i.be);
            if (s_mdma)
                mdma_tim_o <= merge(mdma_tim_o, req_i.wdata,
                                    icr_pkg::ICR_ALL_WMASK,
                                    req_i.be);
            if (s_udma)
                udma_tim_o <= merge(udma_tim_o, req_i.wdata,
                                    icr_pkg::ICR_ALL_WMASK,
                                    req_i.be);
        end
    end

    //--------------------------------------------------------------
    // Task-file shadows and forwarding
    //--------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            tf0_r <= 32'h00000000;
            tf1_r <= 32'h00000000;
            tf2_r <= 32'h00000000;
        end else if (wr_go) begin
            if (s_tf0)
                tf0_r <= merge(tf0_r, req_i.wdata,
                               icr_pkg::ICR_ALL_WMASK, req_i.be);
            if (s_tf1)
                tf1_r <= merge(tf1_r, req_i.wdata,
                               icr_pkg::ICR_ALL_WMASK, req_i.be);
            if (s_tf2)
                tf2_r <= merge(tf2_r, req_i.wdata,
                               icr_pkg::ICR_ALL_WMASK, req_i.be);
        end
    end

    // Every written lane goes to its device register one cycle later, all lanes at once
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ata_o         <= '0;
            ata_cmd_o     <= 1'b0;
            ata_stat_rd_o <= 1'b0;
        end else begin
            ata_o.lanes   <= tf_wr ? req_i.be : 4'h0;
            ata_o.word    <= tf_word;
            ata_o.data    <= req_i.wdata;
            ata_cmd_o     <= cmd_wr;
            ata_stat_rd_o <= st_rd;
        end
    end

    //--------------------------------------------------------------
    // Host answer and outputs
    //--------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            ack_o       <= 1'b0;
            hit_o       <= 1'b0;
            rdata_o     <= 32'h00000000;
            pci_int_o   <= 1'b0;
            pio_iordy_o <= 2'h0;
        end else begin
            ack_o       <= req_i.valid;
            hit_o       <= any_hit;
            rdata_o     <= rd_go ? rd_word : 32'h00000000;
            pci_int_o   <= |(ata_intrq_i
                             & ~sys_r[icr_pkg::ICR_SYS_BLK +: 2]);
            pio_iordy_o <= {|xmode_r[5:4], |xmode_r[1:0]};
        end
    end

    assign io_en_o     = cmd_r[icr_pkg::ICR_CMD_IO];
    assign mem_en_o    = cmd_r[icr_pkg::ICR_CMD_MEM];
    assign master_en_o = cmd_r[icr_pkg::ICR_CMD_MST];
    assign clk_sel_o   = sys_r[icr_pkg::ICR_SYS_CLK +: 2];
    assign rd_thr_o    = fifo_r[5:0];
    assign wr_thr_o    = fifo_r[13:8];
    assign tf_timing_o = tim_r[31:16];
    assign tf_iordy_o  = tim_r[icr_pkg::ICR_TIM_IORDY];
    assign dev0_mode_o = icr_pkg::icr_xmode_e'(xmode_r[1:0]);
    assign dev1_mode_o = icr_pkg::icr_xmode_e'(xmode_r[5:4]);

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    answer_timing_a: assert property (req_i.valid |=> ack_o)
        else $error("ack missing one cycle after request");
    answer_idle_a: assert property (!req_i.valid |=>
        !ack_o && !hit_o && rdata_o == 32'h00000000)
        else $error("answer without request");
    cmd_forward_a: assert property (cmd_wr |=> ata_cmd_o
        && ata_o.data[31:24] == $past(req_i.wdata[31:24]))
        else $error("command byte not forwarded");
    lane_forward_a: assert property (tf_wr |=>
        ata_o.lanes == $past(req_i.be) && ata_o.word == $past(tf_word))
        else $error("task-file lanes not forwarded");
    status_read_a: assert property (st_rd |=>
        rdata_o[31:24] == $past(ata_status_i) && ata_stat_rd_o)
        else $error("status byte not returned");
    int_block_a: assert property (pci_int_o ==
        |($past(ata_intrq_i) & ~$past(sys_r[23:22])))
        else $error("interrupt blocking wrong");
    io_gate_a: assert property (req_i.valid
        && req_i.space == icr_pkg::ICR_SP_IO && !io_en_o |=> !hit_o)
        else $error("io answered while disabled");
    clk_select_a: assert property (s_sys && wr_go && req_i.be[2]
        |=> clk_sel_o == $past(req_i.wdata[21:20]))
        else $error("clock select not taken");
    fifo_thresh_a: assert property (s_fifo && wr_go && req_i.be[0]
        |=> rd_thr_o == $past(req_i.wdata[5:0]))
        else $error("read threshold not taken");
    cable_bit_a: assert property (s_tim && rd_go |=>
        rdata_o[0] == $past(cable80_i))
        else $error("cable bit wrong");
    tf_timing_a: assert property (s_tim && wr_go && &req_i.be[3:2]
        |=> tf_timing_o == $past(req_i.wdata[31:16]))
        else $error("task-file timing not stored");
    tf_iordy_a: assert property (s_tim && wr_go && req_i.be[1]
        |=> tf_iordy_o == $past(req_i.wdata[9]))
        else $error("task-file iordy enable not stored");
    pio_iordy_a: assert property (##1 pio_iordy_o[1] ==
        ($past(dev1_mode_o) != icr_pkg::ICR_PIO_PLAIN)
        && pio_iordy_o[0] == ($past(dev0_mode_o) != icr_pkg::ICR_PIO_PLAIN))
        else $error("pio iordy enable wrong");
    mode_store_a: assert property (s_xm && wr_go && req_i.be[0]
        |=> dev0_mode_o == $past(req_i.wdata[1:0])
            && dev1_mode_o == $past(req_i.wdata[5:4]))
        else $error("transfer mode not stored");
    rom_window_a: assert property (rom_hit |=> hit_o)
        else $error("rom window not answered");
    bar_size_a: assert property (s_bar[5] && rd_go |=>
        rdata_o[7:0] == 8'h00)
        else $error("window 5 low bits not zero");
    pio_update_a: assert property (s_pio && wr_go && req_i.be == 4'hF
        |=> pio_tim_o[15:0] == $past(req_i.wdata[15:0])
            && pio_tim_o[31:16] == $past(req_i.wdata[31:16]))
        else $error("pio_data_timing not stored");
    dma_timing_a: assert property (s_mdma && wr_go
        && req_i.be == 4'hF |=> mdma_tim_o == $past(req_i.wdata))
        else $error("multiword dma timing not stored");
    ultra_dma_timing_a: assert property (s_udma && wr_go
        && req_i.be == 4'hF |=> udma_tim_o == $past(req_i.wdata))
        else $error("ultra dma timing not stored");
    reset_default_a: assert property (disable iff (1'b0)
        !rstn_i |=> tf_timing_o == icr_pkg::ICR_TIM_RST[31:16]
        && pio_tim_o == icr_pkg::ICR_PIO_RST && clk_sel_o == 2'h0)
        else $error("defaults not restored");

    cmd_issue_c:  cover property (cmd_wr ##1 ata_cmd_o);
    status_c:     cover property (st_rd ##1 ack_o);
    rom_c:        cover property (rom_hit);
    int_block_c:  cover property (|ata_intrq_i && sys_r[23:22] == 2'h3);
    udma_mode_c:  cover property (dev1_mode_o == icr_pkg::ICR_UDMA);

endmodule
